//--- hw/misc_instruction_unit.sv
// Miscellaneous instruction group execution unit with APB access
// Contract
// - Decode group opcode; low 11 bits select
// - Signed scale factor from displacement field
// - Normalize A into floating accumulator
// - Normalize clears D; touches T, A, D
// - Denormalize floating accumulator into A
// - Denormalize leaves T and D alone
// - Read special copies selected register to A
// - Status word holds six flag bits
// - Write special loads all bits of status, detect or enable; panel select writes nothing
// - Masked clear resets bits where A is one
// - Masked set sets bits where A is one
// - Status writable only by full write
// - Detect and enable accept masked updates
// - One subinstruction switches interrupts on, off by bit 0
// - WAIT with interrupts off halts
// - After WAIT halt, PC is WAIT plus one
// - Halt lights lamp; button resumes
// - WAIT with interrupts exits level, enters next
// - No pending level: save and idle
// - WAIT operand ignored; word shown on panel
`timescale 1ns/1ps
`default_nettype none
module misc_instruction_unit
  import misc_unit_pkg::*;
#(
  parameter int unsigned LEVELS = 16
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] panel_switches,
  input wire logic continue_button,
  input wire logic [LEVELS-1:0] level_request,
  output logic stop_lamp_red,
  output logic [15:0] instruction_reg,
  output logic [3:0] active_level,
  output logic idle
);
  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] reg_a;          // A accumulator
    logic [15:0] reg_t;          // Sign and exponent
    logic [15:0] reg_d;          // Low mantissa
    logic [15:0] pc;             // Program counter
    logic [STATUS_W-1:0] status; // Programmable flags
    logic [LEVELS-1:0] detect;   // Level detect
    logic [LEVELS-1:0] enable;   // Level enable
    logic ints_on;               // Interrupt system on
    logic halted;                // Programmed stop
    logic idle;                  // Waiting for any enabled request
    logic [3:0] level;           // Level now running
    logic [15:0] saved_pc;       // Resume point of exited level
    logic [15:0] instr;          // Panel display copy
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] sw_s1;          // Synchroniser stages
    logic [15:0] sw_s2;
    logic btn_s1;
    logic btn_s2;
    logic btn_old;               // For rising edge
    logic [LEVELS-1:0] req_s1;
    logic [LEVELS-1:0] req_s2;
  } state_t;

  state_t q;
  state_t d;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic wr_done;
  logic exec;
  logic [2:0] sub;
  logic [1:0] sel;
  logic [9:0] scale;
  logic [LEVELS-1:0] pending;
  logic [LEVELS-1:0] left_after;
  logic [3:0] next_lvl;
  logic btn_rise;

  // Transfer completes at the edge where pready is seen high
  assign wr_done = psel && penable && q.pready && pwrite;
  // Instructions are refused while stopped or idle
  assign exec = wr_done && (paddr[7:0] == OFF_INSTR) && !q.halted &&
                !q.idle && (pwdata[OPC_HI:OPC_LO] == MISC_OPCODE);
  assign sub = pwdata[SUB_HI:SUB_LO];
  assign sel = pwdata[SEL_HI:0];
  // Sign extend the displacement, -128 to +127
  assign scale = {{2{pwdata[DISP_HI]}}, pwdata[DISP_HI:0]};
  assign pending = q.detect & q.enable;
  assign btn_rise = q.btn_s2 && !q.btn_old;

  // Level left pending once the running level is exited
  always_comb
  begin
    left_after = pending;
    left_after[q.level] = 1'b0;
  end

  // Highest pending index wins; a higher index is higher priority
  always_comb
  begin
    next_lvl = 4'h0;
    for (int i = 0; i < LEVELS; i++)
    begin
      if (left_after[i])
      begin
        next_lvl = 4'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion datapath
  // ---------------------------------------------------------------
  logic [15:0] mag;
  logic [15:0] mant;
  logic [4:0] lz;
  logic [9:0] nexp;
  logic [9:0] shift_k;
  logic [15:0] fix_mag;
  logic [15:0] fix_val;
  logic fix_ovf;
  logic flt_ovf;

  // Normalize: shift magnitude until the top bit is one
  always_comb
  begin
    mag = q.reg_a[15] ? 16'(-q.reg_a) : q.reg_a;
    lz = 5'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (mag[i])
      begin
        lz = 5'(15 - i);
      end
    end
    mant = mag << lz;
    // Value is A * 2^(scale-16), so +16 means integer input
    nexp = scale - 10'(lz) + EXP_BIAS;
    flt_ovf = nexp[9] || (nexp > EXP_MAX);
  end

  // Denormalize: A = mantissa * 2^(exp - bias + scale)
  always_comb
  begin
    shift_k = 10'(q.reg_t[7:0]) - EXP_BIAS + scale;
    fix_ovf = 1'b0;
    fix_mag = 16'h0;
    if (q.reg_a == 16'h0)
    begin
      fix_mag = 16'h0;
    end
    else if (!shift_k[9])
    begin
      // Normalized mantissa cannot fit: saturate
      fix_ovf = 1'b1;
      fix_mag = FIX_MAX_POS;
    end
    else if (10'(-shift_k) < 10'd16)
    begin
      fix_mag = q.reg_a >> 4'(-shift_k);
    end
    if (fix_ovf && q.reg_t[15])
    begin
      fix_val = FIX_MAX_NEG;
    end
    else
    begin
      fix_val = q.reg_t[15] ? 16'(-fix_mag) : fix_mag;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    // Two-stage synchronisers for pins
    d.sw_s1 = panel_switches;
    d.sw_s2 = q.sw_s1;
    d.btn_s1 = continue_button;
    d.btn_s2 = q.btn_s1;
    d.btn_old = q.btn_s2;
    d.req_s1 = level_request;
    d.req_s2 = q.req_s1;

    // APB: one wait state, then answer for one cycle
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (psel && penable && !q.pready)
    begin
      d.pready = 1'b1;
      d.prdata = 32'h0;
      if (paddr[7:0] == OFF_INSTR)
      begin
        d.prdata = {16'h0, q.instr};
      end
      else if (paddr[7:0] == OFF_REG_A)
      begin
        d.prdata = {16'h0, q.reg_a};
      end
      else if (paddr[7:0] == OFF_REG_T)
      begin
        d.prdata = {16'h0, q.reg_t};
      end
      else if (paddr[7:0] == OFF_REG_D)
      begin
        d.prdata = {16'h0, q.reg_d};
      end
      else if (paddr[7:0] == OFF_PC)
      begin
        d.prdata = {16'h0, q.pc};
      end
      else if (paddr[7:0] == OFF_STATE)
      begin
        d.prdata = {16'h0, q.level, 2'h0, q.status,
                    1'b0, q.idle, q.halted, q.ints_on};
      end
      else if (paddr[7:0] == OFF_DETECT)
      begin
        d.prdata = 32'(q.detect);
      end
      else if (paddr[7:0] == OFF_ENABLE)
      begin
        d.prdata = 32'(q.enable);
      end
      else
      begin
        // Unmapped low address byte
        d.pslverr = 1'b1;
      end
      if (paddr[31:8] != 24'h0)
      begin
        d.pslverr = 1'b1;
        d.prdata = 32'h0;
      end
    end

    // Direct software access to the working registers
    if (wr_done && !q.pslverr)
    begin
      if (paddr[7:0] == OFF_REG_A)
      begin
        d.reg_a = pwdata[15:0];
      end
      else if (paddr[7:0] == OFF_REG_T)
      begin
        d.reg_t = pwdata[15:0];
      end
      else if (paddr[7:0] == OFF_REG_D)
      begin
        d.reg_d = pwdata[15:0];
      end
      else if (paddr[7:0] == OFF_PC)
      begin
        d.pc = pwdata[15:0];
      end
    end

    // Operator restarts a programmed stop
    if (q.halted && btn_rise)
    begin
      d.halted = 1'b0;
    end

    // Idle ends when any enabled level raises a request
    if (q.idle && (pending != '0))
    begin
      d.idle = 1'b0;
      for (int i = 0; i < LEVELS; i++)
      begin
        if (pending[i])
        begin
          d.level = 4'(i);
        end
      end
    end

    // Instruction execution
    if (exec)
    begin
      d.instr = pwdata[15:0];
      d.pc = q.pc + 16'h1;
      case (sub)
        SUB_FIX_TO_FLOAT:
        begin
          // Floating accumulator is T, A, D together
          if (mag == 16'h0)
          begin
            d.reg_t = 16'h0;
            d.reg_a = 16'h0;
          end
          else
          begin
            d.reg_t = {q.reg_a[15], 7'h0, nexp[7:0]};
            d.reg_a = mant;
            d.status[ST_FLOAT_OVF] = q.status[ST_FLOAT_OVF] | flt_ovf;
          end
          d.reg_d = 16'h0;
        end
        SUB_FLOAT_TO_FIX:
        begin
          // Only A and the overflow flag change
          d.reg_a = fix_val;
          d.status[ST_FLOAT_OVF] = q.status[ST_FLOAT_OVF] | fix_ovf;
        end
        SUB_READ_SPECIAL:
        begin
          case (sel)
            SEL_PANEL: d.reg_a = q.sw_s2;
            SEL_STATUS: d.reg_a = 16'(q.status);
            SEL_DETECT: d.reg_a = 16'(q.detect);
            default: d.reg_a = 16'(q.enable);
          endcase
        end
        SUB_WRITE_SPECIAL:
        begin
          // Panel switches are read only
          case (sel)
            SEL_STATUS: d.status = q.reg_a[STATUS_W-1:0];
            SEL_DETECT: d.detect = q.reg_a[LEVELS-1:0];
            SEL_ENABLE: d.enable = q.reg_a[LEVELS-1:0];
            default: d.status = q.status;
          endcase
        end
        SUB_MASKED_CLEAR:
        begin
          // Status is not reachable by masked forms
          case (sel)
            SEL_DETECT: d.detect = q.detect & ~q.reg_a[LEVELS-1:0];
            SEL_ENABLE: d.enable = q.enable & ~q.reg_a[LEVELS-1:0];
            default: d.status = q.status;
          endcase
        end
        SUB_MASKED_SET:
        begin
          case (sel)
            SEL_DETECT: d.detect = q.detect | q.reg_a[LEVELS-1:0];
            SEL_ENABLE: d.enable = q.enable | q.reg_a[LEVELS-1:0];
            default: d.status = q.status;
          endcase
        end
        SUB_INTERRUPTS:
        begin
          // Bit 0 high turns the system on, low turns it off
          d.ints_on = pwdata[0];
        end
        default:
        begin
          // WAIT; the low operand bits do not matter
          if (!q.ints_on)
          begin
            d.halted = 1'b1;
          end
          else
          begin
            d.detect[q.level] = 1'b0;
            d.saved_pc = q.pc + 16'h1;
            if (left_after != '0)
            begin
              d.level = next_lvl;
            end
            else
            begin
              d.idle = 1'b1;
            end
          end
        end
      endcase
    end

    // Requests set detect bits last, so a set beats a clear
    d.detect = d.detect | q.req_s2;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state record
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign stop_lamp_red = q.halted;
  assign instruction_reg = q.instr;
  assign active_level = q.level;
  assign idle = q.idle;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_wait_halt: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub == SUB_WAIT && !q.ints_on |=> stop_lamp_red)
    else $error("wait did not halt");
  a_wait_pc: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub == SUB_WAIT |=> q.pc == $past(q.pc) + 16'h1)
    else $error("pc not advanced past wait");
  a_button_run: assert property (@(posedge pclk) disable iff (!presetn)
    q.halted && btn_rise |=> !stop_lamp_red)
    else $error("continue did not resume");
  a_norm_dclr: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub == SUB_FIX_TO_FLOAT |=> q.reg_d == 16'h0)
    else $error("normalize left d set");
  a_denorm_keep: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub == SUB_FLOAT_TO_FIX |=> $stable(q.reg_t) && $stable(q.reg_d))
    else $error("denormalize changed t or d");
  a_status_mask: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub[2] && !sub[1] && sel == SEL_STATUS |=> $stable(q.status))
    else $error("masked form changed status");
  a_ints_switch: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub == SUB_INTERRUPTS |=> q.ints_on == $past(pwdata[0]))
    else $error("interrupt switch wrong");
  a_wait_idle: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub == SUB_WAIT && q.ints_on && left_after == '0 |=> idle)
    else $error("wait did not idle");
  a_mset_bits: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sub == SUB_MASKED_SET && sel == SEL_ENABLE |=>
    (q.enable & $past(q.reg_a)) == $past(q.reg_a))
    else $error("masked set missed bits");

endmodule // misc_instruction_unit
`default_nettype wire

//--- hw/misc_unit_pkg.sv
// Constants shared by the miscellaneous instruction unit
package misc_unit_pkg;
  // ---------------------------------------------------------------
  // Instruction word layout
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned OPC_HI = 15;
  localparam int unsigned OPC_LO = 11;
  localparam logic [4:0] MISC_OPCODE = 5'h1A;
  localparam int unsigned SUB_HI = 10;
  localparam int unsigned SUB_LO = 8;
  localparam int unsigned DISP_HI = 7;
  localparam int unsigned SEL_HI = 1;
  // Subinstruction codes in the misc_group field
  localparam logic [2:0] SUB_FIX_TO_FLOAT = 3'h0;
  localparam logic [2:0] SUB_FLOAT_TO_FIX = 3'h1;
  localparam logic [2:0] SUB_READ_SPECIAL = 3'h2;
  localparam logic [2:0] SUB_WRITE_SPECIAL = 3'h3;
  localparam logic [2:0] SUB_MASKED_CLEAR = 3'h4;
  localparam logic [2:0] SUB_MASKED_SET = 3'h5;
  localparam logic [2:0] SUB_INTERRUPTS = 3'h6;
  localparam logic [2:0] SUB_WAIT = 3'h7;
  // Special register selects, bits 1:0
  localparam logic [1:0] SEL_PANEL = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_DETECT = 2'h2;
  localparam logic [1:0] SEL_ENABLE = 2'h3;
  // ---------------------------------------------------------------
  // Floating format: T[15] sign, T[7:0] exponent, A mantissa
  // ---------------------------------------------------------------
  localparam logic [9:0] EXP_BIAS = 10'h080;
  localparam logic [9:0] EXP_MAX = 10'h0FF;
  localparam int unsigned STATUS_W = 6;
  localparam int unsigned ST_FLOAT_OVF = 2;
  localparam logic [15:0] FIX_MAX_POS = 16'h7FFF;
  localparam logic [15:0] FIX_MAX_NEG = 16'h8001;
  // ---------------------------------------------------------------
  // APB register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_REG_A = 8'h04;
  localparam logic [7:0] OFF_REG_T = 8'h08;
  localparam logic [7:0] OFF_REG_D = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_DETECT = 8'h18;
  localparam logic [7:0] OFF_ENABLE = 8'h1C;
endpackage

//--- test/tb.sv
// Self-checking testbench for the miscellaneous instruction unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import misc_unit_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic continue_button = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] panel_switches = 16'h0;
  logic [15:0] level_request = 16'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stop_lamp_red;
  logic [15:0] instruction_reg;
  logic [3:0] active_level;
  logic idle;
  int n_fail = 0; // Mismatches
  int compares = 0; // Comparisons made
  logic [31:0] seed = 32'h0B13FD62; // Fixed seed keeps runs repeatable
  logic [31:0] q, r;
  logic e;
  logic [15:0] v, w, x;
  int s, i;

  misc_instruction_unit #(.LEVELS(16)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_switches(panel_switches), .continue_button(continue_button),
    .level_request(level_request), .stop_lamp_red(stop_lamp_red),
    .instruction_reg(instruction_reg), .active_level(active_level),
    .idle(idle));

  // ---------------------------------------------------------------
  // Clock, helpers and bus tasks
  // ---------------------------------------------------------------
  // 100 MHz clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end

  // Xorshift generator
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected floating form {T, A} of a positive fixed value
  function automatic logic [31:0] norm(input logic [15:0] a, input int sc);
    int n;
    n = 0;
    while (!a[15])
    begin
      a = a << 1;
      n++;
    end
    return {8'h00, 8'(128 + sc - n), a};
  endfunction

  // Instruction word of the group
  function automatic logic [15:0] mk(input logic [2:0] sub,
                                      input logic [7:0] lo);
    return {MISC_OPCODE, sub, lo};
  endfunction

  // Verdict; single exit point of the run
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(negedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      n_fail++;
      $display("ERROR apb no answer");
      end_sim();
    end
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Execute one word and let its effects land
  task automatic exec(input logic [15:0] wd);
    apb(1'b1, {24'h0, OFF_INSTR}, {16'h0, wd});
    repeat (2) @(posedge pclk);
  endtask

  // Read a register, all 32 bits of prdata
  task automatic rd(input logic [7:0] a);
    apb(1'b0, {24'h0, a}, 32'h0);
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    $display("ERROR run timeout");
    end_sim();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STATE);
    chk("state reset", q, 32'h0);
    apb(1'b0, 32'h20, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b1, 32'h104, 32'h1234);
    chk("high addr err", {31'h0, e}, 32'h1);
    // Conversion round trip, scale 16 edge first
    for (i = 0; i < 8; i++)
    begin
      r = rnd();
      v = {1'b0, r[14:0]} | 16'h1;
      w = r[31:16];
      s = (i == 0) ? 16 : int'(r[19:16]) - 4;
      apb(1'b1, {24'h0, OFF_REG_A}, {16'h0, v});
      apb(1'b1, {24'h0, OFF_REG_D}, {16'h0, w});
      exec(mk(SUB_FIX_TO_FLOAT, 8'(s)));
      rd(OFF_REG_T);
      x = q[15:0];
      chk("norm T", q, {16'h0, norm(v, s) >> 16});
      rd(OFF_REG_A);
      chk("norm A", q, {16'h0, norm(v, s) & 32'hFFFF});
      rd(OFF_REG_D);
      chk("norm D", q, 32'h0);
      apb(1'b1, {24'h0, OFF_REG_D}, {16'h0, w});
      exec(mk(SUB_FLOAT_TO_FIX, 8'(-s)));
      rd(OFF_REG_A);
      chk("denorm A", q, {16'h0, v});
      rd(OFF_REG_T);
      chk("denorm T", q, {16'h0, x});
      rd(OFF_REG_D);
      chk("denorm D", q, {16'h0, w});
    end
    // Panel switches into A
    panel_switches <= rnd() >> 8;
    repeat (4) @(posedge pclk);
    exec(mk(SUB_READ_SPECIAL, {6'h0, SEL_PANEL}));
    rd(OFF_REG_A);
    chk("panel read", q, {16'h0, panel_switches});
    // Status word: full write only
    x = rnd();
    apb(1'b1, {24'h0, OFF_REG_A}, {16'h0, x});
    exec(mk(SUB_WRITE_SPECIAL, {6'h0, SEL_STATUS}));
    rd(OFF_STATE);
    chk("status write", {26'h0, q[9:4]}, {26'h0, x[5:0]});
    apb(1'b1, {24'h0, OFF_REG_A}, 32'hFFFF);
    exec(mk(SUB_MASKED_CLEAR, {6'h0, SEL_STATUS}));
    exec(mk(SUB_MASKED_SET, {6'h0, SEL_STATUS}));
    exec(mk(SUB_READ_SPECIAL, {6'h0, SEL_STATUS}));
    rd(OFF_REG_A);
    chk("status masked", q, {26'h0, x[5:0]});
    // Detect and enable: full, masked set, masked clear
    for (i = 0; i < 2; i++)
    begin
      r = rnd();
      v = rnd();
      apb(1'b1, {24'h0, OFF_REG_A}, {16'h0, r[15:0]});
      exec(mk(SUB_WRITE_SPECIAL, {6'h0, i ? SEL_ENABLE : SEL_DETECT}));
      apb(1'b1, {24'h0, OFF_REG_A}, {16'h0, r[31:16]});
      exec(mk(SUB_MASKED_SET, {6'h0, i ? SEL_ENABLE : SEL_DETECT}));
      apb(1'b1, {24'h0, OFF_REG_A}, {16'h0, v});
      exec(mk(SUB_MASKED_CLEAR, {6'h0, i ? SEL_ENABLE : SEL_DETECT}));
      rd(i ? OFF_ENABLE : OFF_DETECT);
      chk("masked ops", q, {16'h0, (r[15:0] | r[31:16]) & ~v});
      apb(1'b1, {24'h0, OFF_REG_A}, 32'h0);
      exec(mk(SUB_WRITE_SPECIAL, {6'h0, i ? SEL_ENABLE : SEL_DETECT}));
    end
    // Interrupt system on then off
    exec(mk(SUB_INTERRUPTS, 8'h01));
    rd(OFF_STATE);
    chk("ints on", {31'h0, q[0]}, 32'h1);
    exec(mk(SUB_INTERRUPTS, 8'h00));
    rd(OFF_STATE);
    chk("ints off", {31'h0, q[0]}, 32'h0);
    // Stop with interrupts off; words ignored while halted
    apb(1'b1, {24'h0, OFF_PC}, 32'h0123);
    exec(mk(SUB_WAIT, 8'h2A));
    chk("lamp on", {31'h0, stop_lamp_red}, 32'h1);
    chk("ir shown", {16'h0, instruction_reg}, {16'h0, mk(SUB_WAIT, 8'h2A)});
    rd(OFF_PC);
    chk("pc after stop", q, 32'h0124);
    exec(mk(SUB_INTERRUPTS, 8'h01));
    rd(OFF_STATE);
    chk("halted state", {30'h0, q[1:0]}, 32'h2);
    continue_button <= 1'b1;
    for (i = 0; i < 20 && stop_lamp_red !== 1'b0; i++) @(posedge pclk);
    continue_button <= 1'b0;
    chk("lamp off", {31'h0, stop_lamp_red}, 32'h0);
    // Give up level with nothing pending, then wake on a request
    apb(1'b1, {24'h0, OFF_REG_A}, 32'h0021);
    exec(mk(SUB_MASKED_SET, {6'h0, SEL_ENABLE}));
    exec(mk(SUB_INTERRUPTS, 8'h01));
    exec(mk(SUB_WAIT, 8'h00));
    chk("idle", {31'h0, idle}, 32'h1);
    level_request[5] <= 1'b1;
    repeat (5) @(posedge pclk);
    level_request[5] <= 1'b0;
    for (i = 0; i < 20 && active_level !== 4'h5; i++) @(posedge pclk);
    chk("woken level", {28'h0, active_level}, 32'h5);
    chk("idle left", {31'h0, idle}, 32'h0);
    // Lower request pends, then WAIT drops to it
    level_request[0] <= 1'b1;
    repeat (5) @(posedge pclk);
    level_request[0] <= 1'b0;
    repeat (2) @(posedge pclk);
    exec(mk(SUB_WAIT, 8'h07));
    chk("next level", {28'h0, active_level}, 32'h0);
    rd(OFF_DETECT);
    chk("exit clears", q, 32'h0001);
    end_sim();
  end
endmodule // tb
`default_nettype wire
